/* logic/lcdrl_col.sv */
`timescale 1ns/1ns
`default_nettype none
module lcdrl_col #(
  parameter int unsigned NROW = 4
) (
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            ce,
  // Write side
  input  wire logic            we,
  input  wire logic [1:0]      wr_row,
  input  wire logic            wr_bit,
  // Display side
  input  wire logic            load,
  input  wire logic [1:0]      rd_row,
  output logic                 seg,
  output logic [NROW-1:0]      bits
);

  logic [NROW-1:0] bits_reg;
  logic            seg_reg;

  // Row index is two bits wide
  if (NROW < 1 || NROW > 4) begin : g_bad
    $error("lcdrl_col: unsupported row count");
  end

  // ****************************************
  // One RAM column and its display latch
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bits_reg <= '0;
      seg_reg  <= 1'b0;
    end else if (ce) begin
      if (we) begin
        bits_reg[wr_row] <= wr_bit;
      end
      // Latch holds one row for the whole phase, RAM may change meanwhile
      if (load) begin
        seg_reg <= bits_reg[rd_row];
      end
    end
  end

  assign seg  = seg_reg;
  assign bits = bits_reg;

endmodule
`default_nettype wire

/* logic/lcdrl_core.sv */
// Operation
// - Internal oscillator drives cascade clock pin out
// - Select high: cascade clock pin is input
// - Frame pulse every twenty-four cascade clock periods
// - Shared sync pin aligns cascaded drivers
// - Display latch holds row data per phase
// - Forty segments from latch and phase
// - Backplanes duplicate each other by mode
// - Display RAM is forty four-bit columns
// - Stored one means element on
// - Rows zero to three follow backplanes
// - Static: eight bits into row zero
// - Mux 1:2: bit pairs, four addresses
// - Mux 1:3: triples, last spare untouched
// - Mux 1:4: quadruples, two addresses
// - Bytes start at loaded pointer address
// - Pointer advances eight, four, three, two
// - Store only when subaddress counter matches pins
// - Mismatch suppresses store, pointer still advances
// - Pointer overflow increments subaddress counter
// - Reset clears pointer, counter; mode 1:4
// - Bits past last address wrap to address zero under the next subaddress
// - Row selector range depends on mode
`timescale 1ns/1ns
`default_nettype none
module lcdrl_core #(
  parameter int unsigned NUM_COL   = lcdrl_pkg::NUM_COL,
  parameter int unsigned OSC_DIV   = lcdrl_pkg::OSC_DIV,
  parameter int unsigned FRAME_DIV = lcdrl_pkg::FRAME_DIV
) (
  // Clock, reset, enable
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Straps
  input  wire logic                osc_source_select,
  input  wire logic [2:0]          hw_subaddress_pins,
  // Cascade clock pin
  input  wire logic                cclk_in,
  output logic                     cclk_out,
  output logic                     cclk_oe,
  // Cascade sync pin, open drain
  input  wire logic                sync_in,
  output logic                     sync_out,
  output logic                     sync_oe,
  // LCD drive
  output logic [NUM_COL-1:0]       segment_outputs,
  output logic [3:0]               backplane_outputs,
  output logic                     frame_out
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Pointer is six bits, divider counters eight
  if (NUM_COL < 8 || NUM_COL > 63 || OSC_DIV < 1 || OSC_DIV > 256
      || FRAME_DIV < 2 || FRAME_DIV > 256) begin : g_bad
    $error("lcdrl_core: unsupported parameter value");
  end

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [5:0] PTR_LAST = 6'(NUM_COL - 1);
  localparam logic [5:0] PTR_LIM  = 6'(NUM_COL);
  localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);
  localparam logic [7:0] FR_LAST  = 8'(FRAME_DIV - 1);
  localparam logic [2:0] BIT_LAST = 3'(lcdrl_pkg::BYTE_BITS - 1);

  logic                  ph_valid_reg;
  logic                  ph_wr_reg;
  logic [7:0]            ph_addr_reg;
  logic                  rd_wait_reg;
  logic [31:0]           hrdata_reg;

  lcdrl_pkg::lcdrl_mode_t mode_reg;
  lcdrl_pkg::lcdrl_ld_t   ld_reg;
  logic [5:0]            ptr_reg;
  logic [2:0]            sub_reg;
  logic [1:0]            wrow_reg;
  logic [2:0]            bcnt_reg;
  logic [7:0]            shift_reg;
  logic                  ack_acc_reg;
  logic                  last_ack_reg;

  logic [7:0]            osc_cnt_reg;
  logic                  osc_reg;
  logic                  cclk_s_reg;
  logic [7:0]            fr_cnt_reg;
  logic [1:0]            row_reg;
  logic                  frame_reg;
  logic                  sync_oe_reg;
  logic                  load_reg;
  logic [3:0]            bp_reg;
  lcdrl_pkg::lcdrl_mode_t dmode_reg;

  logic [NUM_COL*4-1:0]  col_bits;

  // ****************************************
  // Bus decode
  // ****************************************
  wire take      = hsel & hready & htrans[1];
  wire ld_busy   = (ld_reg == lcdrl_pkg::LD_RUN);
  wire rd_first  = ph_valid_reg & ~ph_wr_reg & ~rd_wait_reg;
  wire wr_stall  = ph_valid_reg & ph_wr_reg & ld_busy;
  wire wr_fire   = ph_valid_reg & ph_wr_reg & ~ld_busy & ce;
  wire sel_mode  = (ph_addr_reg == lcdrl_pkg::OFS_MODE);
  wire sel_ptr   = (ph_addr_reg == lcdrl_pkg::OFS_PTR);
  wire sel_sub   = (ph_addr_reg == lcdrl_pkg::OFS_SUB);
  wire sel_data  = (ph_addr_reg == lcdrl_pkg::OFS_DATA);
  wire sel_stat  = (ph_addr_reg == lcdrl_pkg::OFS_STAT);

  // A stopped enable must not let a write complete unseen
  assign hreadyout = ~(ph_valid_reg & (~ce | rd_first | wr_stall));
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  wire [31:0] stat_word = (32'(ld_busy) << lcdrl_pkg::ST_BUSY)
                        | (32'(last_ack_reg) << lcdrl_pkg::ST_ACK)
                        | (32'(row_reg) << lcdrl_pkg::ST_ROW)
                        | (32'(osc_source_select) << lcdrl_pkg::ST_OSC);

  wire [31:0] rd_mux = sel_mode ? {30'h0, mode_reg}
                     : sel_ptr  ? {26'h0, ptr_reg}
                     : sel_sub  ? {29'h0, sub_reg}
                     : sel_stat ? stat_word
                     : 32'h0;

  // ****************************************
  // Bus phase tracking
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_wr_reg    <= 1'b0;
      ph_addr_reg  <= 8'h00;
      rd_wait_reg  <= 1'b0;
      hrdata_reg   <= 32'h0;
    end else if (ce) begin
      if (take) begin
        ph_valid_reg <= 1'b1;
        ph_wr_reg    <= hwrite;
        ph_addr_reg  <= haddr[7:0];
      end else if (hreadyout) begin
        ph_valid_reg <= 1'b0;
      end
      rd_wait_reg <= rd_first;
      if (rd_first) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ****************************************
  // Byte loader
  // ****************************************
  wire [1:0] grp_last = (mode_reg == lcdrl_pkg::MODE_STATIC) ? 2'h0
                      : (mode_reg == lcdrl_pkg::MODE_MUX2)   ? 2'h1
                      : (mode_reg == lcdrl_pkg::MODE_MUX3)   ? 2'h2
                      : 2'h3;
  wire       last_bit = (bcnt_reg == BIT_LAST);
  wire       match    = (sub_reg == hw_subaddress_pins);
  wire       store    = ld_busy & match;
  // A partly filled 1:3 address still counts as used
  wire       adv      = ld_busy & ((wrow_reg == grp_last) | last_bit);
  wire       ptr_wrap = (ptr_reg == PTR_LAST);
  wire       start    = wr_fire & sel_data;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ld_reg       <= lcdrl_pkg::LD_IDLE;
      mode_reg     <= lcdrl_pkg::MODE_MUX4;
      ptr_reg      <= lcdrl_pkg::PTR_RESET;
      sub_reg      <= lcdrl_pkg::SUB_RESET;
      wrow_reg     <= 2'h0;
      bcnt_reg     <= 3'h0;
      shift_reg    <= 8'h00;
      ack_acc_reg  <= 1'b0;
      last_ack_reg <= 1'b0;
    end else if (ce) begin
      if (wr_fire & sel_mode) begin
        mode_reg <= lcdrl_pkg::lcdrl_mode_t'(hwdata[1:0]);
      end
      if (wr_fire & sel_ptr & (hwdata[5:0] < PTR_LIM) & (hwdata[31:6] == 26'h0)) begin
        ptr_reg <= hwdata[5:0];
      end
      if (wr_fire & sel_sub) begin
        sub_reg <= hwdata[2:0];
      end
      unique case (ld_reg)
        lcdrl_pkg::LD_IDLE: begin
          if (start) begin
            ld_reg      <= lcdrl_pkg::LD_RUN;
            shift_reg   <= hwdata[7:0];
            bcnt_reg    <= 3'h0;
            wrow_reg    <= 2'h0;
            ack_acc_reg <= 1'b0;
          end
        end
        lcdrl_pkg::LD_RUN: begin
          shift_reg   <= {shift_reg[6:0], 1'b0};
          bcnt_reg    <= bcnt_reg + 3'h1;
          ack_acc_reg <= ack_acc_reg | match;
          wrow_reg    <= adv ? 2'h0 : wrow_reg + 2'h1;
          if (adv) begin
            ptr_reg <= ptr_wrap ? 6'h00 : ptr_reg + 6'h01;
            if (ptr_wrap) begin
              sub_reg <= sub_reg + 3'h1;
            end
          end
          if (last_bit) begin
            ld_reg       <= lcdrl_pkg::LD_IDLE;
            last_ack_reg <= ack_acc_reg | match;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Clock source and frame timing
  // ****************************************
  wire osc_wrap = (osc_cnt_reg == OSC_LAST);
  wire tick_int = osc_wrap & ~osc_reg;
  wire tick_ext = cclk_in & ~cclk_s_reg;
  wire tick     = osc_source_select ? tick_ext : tick_int;
  wire fr_wrap  = tick & (fr_cnt_reg == FR_LAST);
  // Our own pull must not restart us
  wire resync   = ~sync_in & ~sync_oe_reg;
  wire [1:0] disp_last = (dmode_reg == lcdrl_pkg::MODE_STATIC) ? 2'h0
                       : (dmode_reg == lcdrl_pkg::MODE_MUX2)   ? 2'h1
                       : (dmode_reg == lcdrl_pkg::MODE_MUX3)   ? 2'h2
                       : 2'h3;
  wire row_end  = (row_reg == disp_last);
  // Mode swap waits for a row step and restarts at row 0, never a dark backplane
  wire row_zero = row_end | (dmode_reg != mode_reg);

  assign cclk_out = osc_reg;
  assign cclk_oe  = ~osc_source_select;
  assign sync_out = 1'b0;
  assign sync_oe  = sync_oe_reg;
  assign frame_out = frame_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_reg <= 8'h00;
      osc_reg     <= 1'b0;
      cclk_s_reg  <= 1'b0;
    end else if (ce) begin
      osc_cnt_reg <= osc_wrap ? 8'h00 : osc_cnt_reg + 8'h01;
      if (osc_wrap) begin
        osc_reg <= ~osc_reg;
      end
      cclk_s_reg <= cclk_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fr_cnt_reg  <= 8'h00;
      row_reg     <= 2'h0;
      frame_reg   <= 1'b0;
      sync_oe_reg <= 1'b0;
      load_reg    <= 1'b0;
      dmode_reg   <= lcdrl_pkg::MODE_MUX4;
    end else if (ce) begin
      frame_reg   <= fr_wrap;
      load_reg    <= fr_wrap | resync;
      sync_oe_reg <= fr_wrap & row_zero;
      if (resync) begin
        fr_cnt_reg <= 8'h00;
        row_reg    <= 2'h0;
        dmode_reg  <= mode_reg;
      end else if (tick) begin
        fr_cnt_reg <= fr_wrap ? 8'h00 : fr_cnt_reg + 8'h01;
        if (fr_wrap) begin
          row_reg   <= row_zero ? 2'h0 : row_reg + 2'h1;
          dmode_reg <= mode_reg;
        end
      end
    end
  end

  // ****************************************
  // Backplane outputs
  // ****************************************
  wire [3:0] bp_hot = 4'h1 << row_reg;
  wire [3:0] bp_next = (dmode_reg == lcdrl_pkg::MODE_STATIC) ? 4'hf
                     : (dmode_reg == lcdrl_pkg::MODE_MUX2) ? {bp_hot[1:0], bp_hot[1:0]}
                     : (dmode_reg == lcdrl_pkg::MODE_MUX3) ? {bp_hot[1], bp_hot[2:0]}
                     : bp_hot;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bp_reg <= 4'h0;
    end else if (ce) begin
      bp_reg <= bp_next;
    end
  end

  assign backplane_outputs = bp_reg;

  // ****************************************
  // Display RAM columns
  // ****************************************
  for (genvar c = 0; c < NUM_COL; c++) begin : g_col
    lcdrl_col #(
      .NROW   (lcdrl_pkg::NUM_ROW)
    ) u_col (
      .hclk   (hclk),
      .hresetn(hresetn),
      .ce     (ce),
      .we     (store & (ptr_reg == 6'(c))),
      .wr_row (wrow_reg),
      .wr_bit (shift_reg[7]),
      .load   (load_reg),
      .rd_row (row_reg),
      .seg    (segment_outputs[c]),
      .bits   (col_bits[c*4 +: 4])
    );
  end

endmodule
`default_nettype wire

/* logic/lcdrl_pkg.sv */
`default_nettype none
package lcdrl_pkg;

  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int unsigned NUM_COL   = 40;
  localparam int unsigned NUM_ROW   = 4;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FRAME_DIV = 24;
  localparam int unsigned OSC_DIV   = 4;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PTR  = 8'h04;
  localparam logic [7:0] OFS_SUB  = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // ****************************************
  // Status fields
  // ****************************************
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_ACK  = 1;
  localparam int unsigned ST_ROW  = 4;
  localparam int unsigned ST_OSC  = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [2:0] SUB_RESET = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_MUX4   = 2'b00,
    MODE_STATIC = 2'b01,
    MODE_MUX2   = 2'b10,
    MODE_MUX3   = 2'b11
  } lcdrl_mode_t;

  typedef enum logic {
    LD_IDLE = 1'b0,
    LD_RUN  = 1'b1
  } lcdrl_ld_t;

endpackage
`default_nettype wire

/* verification/lcd_ram_loader_mux_timing_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module lcd_ram_loader_mux_timing_bench;
  logic             hclk, hresetn, hsel, hwrite, osc_source_select, ext_en, sync_req, s_ack;
  logic [1:0]       htrans;
  logic [2:0]       hw_subaddress_pins, s_sub;
  logic [5:0]       s_ptr;
  logic [31:0]      haddr, hwdata;
  logic [3:0]       ram [40];
  int               seed, miscompares, comparisons;
  wire logic        hready, hreadyout, hresp, cclk_in, cclk_out, cclk_oe, peer_clk;
  wire logic        sync_in, sync_out, sync_oe, sync_pull, frame_out;
  wire logic [31:0] hrdata;
  wire logic [39:0] segment_outputs;
  wire logic [3:0]  backplane_outputs;

  // ****
  // Wiring; sync pin has a pull-up
  // ****
  assign hready = hreadyout;
  assign cclk_in = cclk_oe ? cclk_out : peer_clk;
  assign sync_in = !(sync_oe || sync_pull);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  lcdrl_core #(.OSC_DIV(1)) dut_u (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .osc_source_select,
    .hw_subaddress_pins, .cclk_in, .cclk_out, .cclk_oe, .sync_in, .sync_out, .sync_oe,
    .segment_outputs, .backplane_outputs, .frame_out);
  lcdrl_peer peer_u (.hclk, .ext_en, .sync_req, .cclk_drive(peer_clk), .sync_pull);

  // ****
  // Tasks
  // ****
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 300);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 300);
    q = hrdata;
    chk(40'(hresp), 40'h0);
    if (n >= 300) begin
      miscompares++;
      close_out;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [39:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk({8'h0, q}, e);
  endtask
  task automatic waitbp(input logic [3:0] v);
    int n;
    n = 0;
    while (backplane_outputs !== v && n < 600) begin
      @(posedge hclk);
      n++;
    end
    if (n == 600) begin
      miscompares++;
      close_out;
    end
    else chk(40'(backplane_outputs), 40'(v));
  endtask
  // Expected RAM, pointer, counter and ack after one byte
  function automatic void put(input logic [1:0] m, input logic [7:0] b, input logic [2:0] hw);
    int g;
    int a;
    g = m == 2'h0 ? 4 : m == 2'h1 ? 1 : m == 2'h2 ? 2 : 3;
    a = s_ptr;
    s_ack = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i == 8 || (i > 0 && i % g == 0)) a++;
      if (a == 40) s_sub++;
      if (a == 40) a = 0;
      if (i < 8 && s_sub === hw) ram[a][i % g] = b[7 - i];
      if (i < 8 && s_sub === hw) s_ack = 1'b1;
    end
    s_ptr = 6'(a);
  endfunction
  function automatic logic [39:0] rowv(input int r);
    logic [39:0] v;
    foreach (ram[c]) v[c] = ram[c][r];
    return v;
  endfunction

  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] t;
    logic [7:0]  b;
    logic [2:0]  pv;
    logic [1:0]  m;
    int          n;
    seed = 92;
    miscompares = 0;
    comparisons = 0;
    {hresetn, hsel, hwrite, osc_source_select, ext_en, sync_req} = 6'h0;
    {htrans, hw_subaddress_pins, haddr, hwdata} = '0;
    foreach (ram[c]) ram[c] = 4'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(40'(backplane_outputs), 40'h1);
    rchk(lcdrl_pkg::OFS_MODE, 40'h0);
    rchk(lcdrl_pkg::OFS_PTR, 40'h0);
    rchk(lcdrl_pkg::OFS_SUB, 40'h0);
    for (int i = 0; i < 40; i++) begin
      pv = 3'($random(seed));
      hw_subaddress_pins <= pv;
      m = 2'($random(seed));
      s_ptr = (i < 4) ? 6'(39 - i) : 6'($unsigned($random(seed)) % 40);
      s_sub = ($random(seed) & 1) ? pv : 3'($random(seed));
      b = 8'($random(seed));
      wr(lcdrl_pkg::OFS_MODE, {30'h0, m});
      wr(lcdrl_pkg::OFS_PTR, {26'h0, s_ptr});
      wr(lcdrl_pkg::OFS_PTR, 32'h3f);
      wr(lcdrl_pkg::OFS_SUB, {29'h0, s_sub});
      put(m, b, pv);
      wr(lcdrl_pkg::OFS_DATA, {24'h0, b});
      wr(8'h14, 32'h0);
      rchk(lcdrl_pkg::OFS_PTR, 40'(s_ptr));
      rchk(lcdrl_pkg::OFS_SUB, 40'(s_sub));
      bus(1'b0, lcdrl_pkg::OFS_STAT, 32'h0, t);
      chk(40'(t[lcdrl_pkg::ST_ACK]), 40'(s_ack));
    end
    wr(lcdrl_pkg::OFS_MODE, 32'h0);
    // Latch may predate the last bytes: let it reload before rows are compared
    waitbp(4'h8);
    for (int r = 0; r < 4; r++) begin
      waitbp(4'(1 << r));
      repeat (3) @(posedge hclk);
      chk(segment_outputs, rowv(r));
    end
    for (int k = 1; k < 4; k++) begin
      wr(lcdrl_pkg::OFS_MODE, 32'(k));
      waitbp(k == 1 ? 4'hf : k == 2 ? 4'h5 : 4'ha);
    end
    wr(lcdrl_pkg::OFS_MODE, 32'h0);
    waitbp(4'h2);
    sync_req <= 1'b1;
    @(posedge hclk);
    sync_req <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(40'(backplane_outputs), 40'h1);
    osc_source_select <= 1'b1;
    ext_en <= 1'b1;
    @(posedge hclk);
    chk(40'(cclk_oe), 40'h0);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do @(posedge hclk); while (frame_out !== 1'b1 && ++n < 1000);
      if (n >= 1000) begin
        miscompares++;
        close_out;
      end
    end
    // Peer clock rises once every six bench clocks
    chk(40'(n + 1), 40'(6 * lcdrl_pkg::FRAME_DIV));
    bus(1'b0, lcdrl_pkg::OFS_STAT, 32'h0, t);
    chk(40'(t[lcdrl_pkg::ST_OSC]), 40'h1);
    osc_source_select <= 1'b0;
    ext_en <= 1'b0;
    repeat (200) @(posedge hclk);
    close_out;
  end
endmodule
`default_nettype wire

/* verification/lcdrl_core_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker
// ****
module lcdrl_core_checker #(
  parameter int unsigned NUM_COL   = 40,
  parameter int unsigned OSC_DIV   = 4,
  parameter int unsigned FRAME_DIV = 24
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Bus
  input  wire logic               hsel,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic               hready,
  input  wire logic               hreadyout,
  // Pins
  input  wire logic               osc_source_select,
  input  wire logic               cclk_oe,
  input  wire logic               cclk_out,
  input  wire logic               sync_in,
  input  wire logic               sync_out,
  input  wire logic               sync_oe,
  input  wire logic [NUM_COL-1:0] segment_outputs,
  input  wire logic [3:0]         backplane_outputs,
  input  wire logic               frame_out
);
  logic [1:0]  live;
  int unsigned gap;
  int unsigned hold;
  logic        cclk_q;

  // Gap only trusted between two undisturbed internal frames
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live   <= 2'h0;
      gap    <= 0;
      hold   <= 0;
      cclk_q <= 1'b0;
    end else begin
      live   <= {live[0], 1'b1};
      cclk_q <= cclk_out;
      hold   <= (cclk_out != cclk_q) ? 0 : hold + 1;
      if (osc_source_select || (!sync_in && !sync_oe)) gap <= 0;
      else if (frame_out) gap <= 1;
      else if (gap != 0) gap <= gap + 1;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_clk_dir;
    cclk_oe == !osc_source_select;
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction wrong");
  property p_clk_run;
    live[1] && !osc_source_select |-> OSC_DIV >= hold;
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("cascade clock stalled");
  property p_frame_gap;
    frame_out && gap != 0 |-> gap == 2 * OSC_DIV * FRAME_DIV;
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("frame spacing wrong");
  property p_frame_pulse;
    frame_out |=> !frame_out;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
  property p_bp_set;
    live[1] |-> backplane_outputs inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'ha, 4'hf};
  endproperty
  a_bp_set: assert property (p_bp_set) else $error("backplane pattern illegal");
  property p_bp_step;
    live[1] && $changed(backplane_outputs) |-> $past(frame_out) || $past(frame_out, 2)
      || !$past(sync_in) || !$past(sync_in, 2);
  endproperty
  a_bp_step: assert property (p_bp_step) else $error("row moved off frame");
  property p_seg_hold;
    live[1] && $changed(segment_outputs) |-> $past(frame_out) || $past(frame_out, 2)
      || $past(frame_out, 3) || !$past(sync_in, 2) || !$past(sync_in, 3);
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("latch changed mid phase");
  property p_sync_pulse;
    sync_oe |-> !sync_out ##1 !sync_oe ##[0:1] backplane_outputs[0];
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse wrong");
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  c_sync: cover property (sync_oe);
  c_dup: cover property (backplane_outputs == 4'ha);
  c_gap: cover property (frame_out && gap != 0);
endmodule

bind lcdrl_core lcdrl_core_checker #(.NUM_COL(NUM_COL), .OSC_DIV(OSC_DIV), .FRAME_DIV(FRAME_DIV))
  chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .osc_source_select,
  .cclk_oe, .cclk_out, .sync_in, .sync_out, .sync_oe, .segment_outputs, .backplane_outputs,
  .frame_out);
`default_nettype wire

/* verification/lcdrl_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Cascade peer on clock and sync pins
// ****
module lcdrl_peer (
  // Clock
  input  wire logic hclk,
  // Control
  input  wire logic ext_en,
  input  wire logic sync_req,
  // Pin drive
  output logic      cclk_drive,
  output logic      sync_pull
);
  logic [2:0] ph = 3'h0;

  always @(posedge hclk) begin
    ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
  end
  // Parks low when unused, so no stray edges
  assign cclk_drive = ext_en && (ph >= 3'h3);
  // Open drain: only pulls, the pull-up restores
  assign sync_pull = sync_req;
endmodule
`default_nettype wire
